// ===== design/fbes_pkg.sv
// fbes_pkg: constants for the front-end and branch event selector
// assumes: register port with 32-bit data and byte addresses, single core clock
package fbes_pkg;

	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;

	// register byte offsets
	localparam logic [7:0] OFS_SELECT = 8'h00;
	localparam logic [7:0] OFS_COUNT = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;

	// select register fields
	localparam int SEL_EVENT_LSB = 0;
	localparam int SEL_QUAL_LSB = 8;
	localparam int SEL_THRESH_LSB = 16;
	localparam int SEL_EDGE_BIT = 24;
	localparam int SEL_ENABLE_BIT = 25;
	localparam logic [31:0] SEL_WR_MASK = 32'h03FF_FFFF;
	localparam logic [31:0] SELECT_RESET = 32'h0000_0000;
	localparam logic [31:0] COUNT_RESET = 32'h0000_0000;

	// status register fields
	localparam int STS_MATCH_BIT = 0;
	localparam int STS_CMP_BIT = 1;

	// event numbers
	localparam logic [7:0] EVT_DECODE_QUEUE = 8'h79;
	localparam logic [7:0] EVT_FETCH_MISS = 8'h80;
	localparam logic [7:0] EVT_TRANSLATION = 8'h85;
	localparam logic [7:0] EVT_LENGTH_DECODE = 8'h87;
	localparam logic [7:0] EVT_BRANCH_EXEC = 8'h88;
	localparam logic [7:0] EVT_BRANCH_MISP = 8'h89;

	// decode queue qualifiers
	localparam logic [7:0] Q_DQ_EMPTY = 8'h02;
	localparam logic [7:0] Q_DQ_LEGACY = 8'h04;
	localparam logic [7:0] Q_DQ_CACHE = 8'h08;
	localparam logic [7:0] Q_DQ_MS_CACHE = 8'h10;
	localparam logic [7:0] Q_DQ_MS_LEGACY = 8'h20;
	localparam logic [7:0] Q_DQ_MS_ALL = 8'h30;
	localparam logic [7:0] Q_DQ_LEGACY_MS = 8'h24;
	localparam logic [7:0] Q_DQ_CACHE_MS = 8'h18;
	localparam logic [7:0] Q_DQ_ALL = 8'h3C;

	// fetch, translation and length decoder qualifiers
	localparam logic [7:0] Q_FETCH_MISS = 8'h02;
	localparam logic [7:0] Q_TR_WALK = 8'h01;
	localparam logic [7:0] Q_TR_DONE = 8'h02;
	localparam logic [7:0] Q_TR_BUSY = 8'h04;
	localparam logic [7:0] Q_TR_L2_HIT = 8'h10;
	localparam logic [7:0] Q_LD_PREFIX = 8'h01;
	localparam logic [7:0] Q_LD_IQ_FULL = 8'h04;

	// branch qualifiers: low six bits pick the class, bit 6 not taken, bit 7 taken
	localparam logic [7:0] Q_BR_NT_COND = 8'h41;
	localparam logic [7:0] Q_BR_TK_COND = 8'h81;
	localparam logic [7:0] Q_BR_TK_DIRECT = 8'h82;
	localparam logic [7:0] Q_BR_TK_INDIRECT = 8'h84;
	localparam logic [7:0] Q_BR_TK_RETURN = 8'h88;
	localparam logic [7:0] Q_BR_TK_DCALL = 8'h90;
	localparam logic [7:0] Q_BR_TK_ICALL = 8'hA0;
	localparam logic [7:0] Q_BR_ALL_COND = 8'hC1;
	localparam logic [7:0] Q_BR_ALL_DIRECT = 8'hC2;
	localparam logic [7:0] Q_BR_ALL_INDIRECT = 8'hC4;
	localparam logic [7:0] Q_BR_ALL_RETURN = 8'hC8;
	localparam logic [7:0] Q_BR_ALL_DCALL = 8'hD0;
	localparam logic [7:0] Q_BR_ALL = 8'hFF;
	localparam int BR_CLASS_W = 6;
	localparam int BR_NT_BIT = 6;
	localparam int BR_TK_BIT = 7;

	// uop source bits inside the decode queue qualifier
	localparam int DQ_LEGACY_BIT = 2;
	localparam int DQ_CACHE_BIT = 3;
	localparam int DQ_MS_CACHE_BIT = 4;
	localparam int DQ_MS_LEGACY_BIT = 5;

endpackage : fbes_pkg

// ===== design/fbes_event_select.sv
// fbes_event_select: event selection, qualification and counting for one monitor counter
// assumes: all event inputs come from logic on ref_clk; register port as a simple strobe slave
`timescale 1ns/10ps

module fbes_event_select #(
	parameter int UOP_W = 3
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// register port
	input wire logic [fbes_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [fbes_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [fbes_pkg::DATA_W-1:0] reg_rdata,
	// decode queue and uop sources
	input wire logic decode_queue_empty,
	input wire logic [UOP_W-1:0] legacy_decode_path_uops,
	input wire logic [UOP_W-1:0] decoded_uop_cache_uops,
	input wire logic [UOP_W-1:0] microcode_sequencer_cache_uops,
	input wire logic [UOP_W-1:0] microcode_sequencer_legacy_uops,
	// instruction fetch and translation
	input wire logic instruction_fetch_miss,
	input wire logic translation_miss_walk,
	input wire logic translation_walk_done,
	input wire logic page_miss_handler_busy,
	input wire logic second_level_translation_buffer_hit,
	// length decoder
	input wire logic length_changing_prefix_stall,
	input wire logic instruction_queue_full_stall,
	// branch execution
	input wire logic branch_valid,
	input wire logic [fbes_pkg::BR_CLASS_W-1:0] branch_class,
	input wire logic branch_taken,
	input wire logic branch_mispredicted,
	// status
	output logic event_count_active,
	output logic [fbes_pkg::DATA_W-1:0] event_count
);

	localparam int INC_W = UOP_W + 2;

	////////////////////////////////////////////////////////////////////////////
	// registers

	logic [fbes_pkg::DATA_W-1:0] select_reg;
	logic [fbes_pkg::DATA_W-1:0] count_reg;
	logic [fbes_pkg::DATA_W-1:0] count_next;
	logic cmp_prev_reg;
	logic [7:0] evt_num;
	logic [7:0] evt_qual;
	logic [7:0] thresh;
	logic edge_en;
	logic count_en;
	logic sel_match;
	logic [INC_W-1:0] raw_inc;
	logic cmp_now;
	logic [INC_W-1:0] qual_inc;
	logic branch_hit;
	logic branch_class_hit;
	logic branch_dir_hit;
	logic sel_write;
	logic count_write;
	logic [fbes_pkg::DATA_W-1:0] status_word;

	assign evt_num = select_reg[fbes_pkg::SEL_EVENT_LSB +: 8];
	assign evt_qual = select_reg[fbes_pkg::SEL_QUAL_LSB +: 8];
	assign thresh = select_reg[fbes_pkg::SEL_THRESH_LSB +: 8];
	assign edge_en = select_reg[fbes_pkg::SEL_EDGE_BIT];
	assign count_en = select_reg[fbes_pkg::SEL_ENABLE_BIT];
	assign sel_write = reg_wr && (reg_addr == fbes_pkg::OFS_SELECT);
	assign count_write = reg_wr && (reg_addr == fbes_pkg::OFS_COUNT);

	// reserved bits are dropped here so they always read back as zero
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			select_reg <= fbes_pkg::SELECT_RESET;
		end else if (sel_write) begin
			select_reg <= reg_wdata & fbes_pkg::SEL_WR_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// supported encodings

	always_comb begin
		sel_match = 1'b0;
		case (evt_num)
			fbes_pkg::EVT_DECODE_QUEUE: begin
				case (evt_qual)
					fbes_pkg::Q_DQ_EMPTY, fbes_pkg::Q_DQ_LEGACY, fbes_pkg::Q_DQ_CACHE,
					fbes_pkg::Q_DQ_MS_CACHE, fbes_pkg::Q_DQ_MS_LEGACY, fbes_pkg::Q_DQ_MS_ALL,
					fbes_pkg::Q_DQ_LEGACY_MS, fbes_pkg::Q_DQ_CACHE_MS, fbes_pkg::Q_DQ_ALL: begin
						sel_match = 1'b1;
					end
					default: begin
						sel_match = 1'b0;
					end
				endcase
			end
			fbes_pkg::EVT_FETCH_MISS: begin
				case (evt_qual)
					fbes_pkg::Q_FETCH_MISS: begin
						sel_match = 1'b1;
					end
					default: begin
						sel_match = 1'b0;
					end
				endcase
			end
			fbes_pkg::EVT_TRANSLATION: begin
				case (evt_qual)
					fbes_pkg::Q_TR_WALK: begin
						sel_match = 1'b1;
					end
					fbes_pkg::Q_TR_DONE: begin
						sel_match = 1'b1;
					end
					fbes_pkg::Q_TR_BUSY: begin
						sel_match = 1'b1;
					end
					fbes_pkg::Q_TR_L2_HIT: begin
						sel_match = 1'b1;
					end
					default: begin
						sel_match = 1'b0;
					end
				endcase
			end
			fbes_pkg::EVT_LENGTH_DECODE: begin
				case (evt_qual)
					fbes_pkg::Q_LD_PREFIX: begin
						sel_match = 1'b1;
					end
					fbes_pkg::Q_LD_IQ_FULL: begin
						sel_match = 1'b1;
					end
					default: begin
						sel_match = 1'b0;
					end
				endcase
			end
			fbes_pkg::EVT_BRANCH_EXEC: begin
				case (evt_qual)
					fbes_pkg::Q_BR_NT_COND, fbes_pkg::Q_BR_TK_COND, fbes_pkg::Q_BR_ALL_COND: begin
						sel_match = 1'b1;
					end
					fbes_pkg::Q_BR_TK_DIRECT, fbes_pkg::Q_BR_TK_INDIRECT, fbes_pkg::Q_BR_TK_RETURN: begin
						sel_match = 1'b1;
					end
					fbes_pkg::Q_BR_TK_DCALL, fbes_pkg::Q_BR_TK_ICALL: begin
						sel_match = 1'b1;
					end
					fbes_pkg::Q_BR_ALL_DIRECT, fbes_pkg::Q_BR_ALL_INDIRECT, fbes_pkg::Q_BR_ALL_RETURN,
					fbes_pkg::Q_BR_ALL_DCALL, fbes_pkg::Q_BR_ALL: begin
						sel_match = 1'b1;
					end
					default: begin
						sel_match = 1'b0;
					end
				endcase
			end
			fbes_pkg::EVT_BRANCH_MISP: begin
				case (evt_qual)
					fbes_pkg::Q_BR_NT_COND, fbes_pkg::Q_BR_TK_COND: begin
						sel_match = 1'b1;
					end
					fbes_pkg::Q_BR_TK_INDIRECT, fbes_pkg::Q_BR_TK_RETURN, fbes_pkg::Q_BR_TK_DCALL,
					fbes_pkg::Q_BR_TK_ICALL: begin
						sel_match = 1'b1;
					end
					default: begin
						sel_match = 1'b0;
					end
				endcase
			end
			default: begin
				sel_match = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// raw per-cycle count for the selected event

	// class bits must overlap and the direction bit must agree
	assign branch_class_hit = |(branch_class & evt_qual[fbes_pkg::BR_CLASS_W-1:0]);
	assign branch_dir_hit = branch_taken ? evt_qual[fbes_pkg::BR_TK_BIT] : evt_qual[fbes_pkg::BR_NT_BIT];
	assign branch_hit = branch_valid && branch_class_hit && branch_dir_hit;

	always_comb begin
		raw_inc = '0;
		case (evt_num)
			fbes_pkg::EVT_DECODE_QUEUE: begin
				if (evt_qual == fbes_pkg::Q_DQ_EMPTY) begin
					raw_inc = INC_W'(decode_queue_empty);
				end else begin
					if (evt_qual[fbes_pkg::DQ_LEGACY_BIT]) begin
						raw_inc = raw_inc + INC_W'(legacy_decode_path_uops);
					end
					if (evt_qual[fbes_pkg::DQ_CACHE_BIT]) begin
						raw_inc = raw_inc + INC_W'(decoded_uop_cache_uops);
					end
					if (evt_qual[fbes_pkg::DQ_MS_CACHE_BIT]) begin
						raw_inc = raw_inc + INC_W'(microcode_sequencer_cache_uops);
					end
					if (evt_qual[fbes_pkg::DQ_MS_LEGACY_BIT]) begin
						raw_inc = raw_inc + INC_W'(microcode_sequencer_legacy_uops);
					end
				end
			end
			fbes_pkg::EVT_FETCH_MISS: begin
				raw_inc = INC_W'(instruction_fetch_miss);
			end
			fbes_pkg::EVT_TRANSLATION: begin
				case (evt_qual)
					fbes_pkg::Q_TR_WALK: begin
						raw_inc = INC_W'(translation_miss_walk);
					end
					fbes_pkg::Q_TR_DONE: begin
						raw_inc = INC_W'(translation_walk_done);
					end
					fbes_pkg::Q_TR_BUSY: begin
						raw_inc = INC_W'(page_miss_handler_busy);
					end
					fbes_pkg::Q_TR_L2_HIT: begin
						raw_inc = INC_W'(second_level_translation_buffer_hit);
					end
					default: begin
						raw_inc = '0;
					end
				endcase
			end
			fbes_pkg::EVT_LENGTH_DECODE: begin
				case (evt_qual)
					fbes_pkg::Q_LD_PREFIX: begin
						raw_inc = INC_W'(length_changing_prefix_stall);
					end
					fbes_pkg::Q_LD_IQ_FULL: begin
						raw_inc = INC_W'(instruction_queue_full_stall);
					end
					default: begin
						raw_inc = '0;
					end
				endcase
			end
			fbes_pkg::EVT_BRANCH_EXEC: begin
				raw_inc = INC_W'(branch_hit);
			end
			fbes_pkg::EVT_BRANCH_MISP: begin
				raw_inc = INC_W'(branch_hit && branch_mispredicted);
			end
			default: begin
				raw_inc = '0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// threshold and edge qualification

	// a zero threshold still compares against one so edge mode has a meaning
	assign cmp_now = (thresh == 8'h00) ? (raw_inc != '0) : (8'(raw_inc) >= thresh);

	always_comb begin
		if (edge_en) begin
			qual_inc = INC_W'(cmp_now && !cmp_prev_reg);
		end else if (thresh != 8'h00) begin
			qual_inc = INC_W'(cmp_now);
		end else begin
			qual_inc = raw_inc;
		end
	end

	// previous comparison tracks every cycle so a re-enable sees real history
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_prev_reg <= 1'b0;
		end else begin
			cmp_prev_reg <= cmp_now && sel_match;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// counter

	always_comb begin
		count_next = count_reg;
		// a software write wins over an increment in the same cycle
		if (count_write) begin
			count_next = reg_wdata;
		end else if (count_en && sel_match) begin
			count_next = count_reg + fbes_pkg::DATA_W'(qual_inc);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= fbes_pkg::COUNT_RESET;
		end else begin
			count_reg <= count_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs and read port

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			event_count <= fbes_pkg::COUNT_RESET;
		end else begin
			event_count <= count_next;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			event_count_active <= 1'b0;
		end else begin
			event_count_active <= count_en && sel_match;
		end
	end

	always_comb begin
		status_word = '0;
		status_word[fbes_pkg::STS_MATCH_BIT] = sel_match;
		status_word[fbes_pkg::STS_CMP_BIT] = cmp_prev_reg;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				fbes_pkg::OFS_SELECT: begin
					reg_rdata <= select_reg;
				end
				fbes_pkg::OFS_COUNT: begin
					reg_rdata <= count_reg;
				end
				fbes_pkg::OFS_STATUS: begin
					reg_rdata <= status_word;
				end
				default: begin
					reg_rdata <= '0;
				end
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

endmodule : fbes_event_select

// ===== bench/fbes_frontend_model.sv
// fbes_frontend_model: random activity of the decode, fetch, translation and branch units
// assumes: run is driven on ref_clk; outputs change just after rising edges
`timescale 1ns/10ps
module fbes_frontend_model #(
	parameter int UOP_W = 3
) (
	// control
	input wire logic ref_clk,
	input wire logic run,
	// uop counts: legacy, cache, sequencer by cache, sequencer by legacy
	output logic [4*UOP_W-1:0] uops,
	// single-bit events and branch attributes
	output logic [10:0] flags,
	output logic [5:0] branch_class
);
	logic [31:0] r = '0;

	// uops and flags drop to zero while stopped so nothing counts; branch_class rests at 6'h01
	always @(posedge ref_clk) r <= run ? $urandom : '0;
	assign uops = r[4*UOP_W-1:0];
	assign flags = r[22:12];
	assign branch_class = 6'h01 << (r[31:29] % 3'd6);
endmodule : fbes_frontend_model

// ===== bench/fbes_event_select_sva.sv
// fbes_event_select_sva: port checks of the event selector
// assumes: bound into fbes_event_select, one clock domain
`timescale 1ns/10ps
module fbes_event_select_sva #(
	parameter int UOP_W = 3
) (
	// clock, reset and register port
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [fbes_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [fbes_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	// watched events and count
	input wire logic decode_queue_empty,
	input wire logic [UOP_W-1:0] legacy_decode_path_uops,
	input wire logic [UOP_W-1:0] microcode_sequencer_cache_uops,
	input wire logic instruction_queue_full_stall,
	input wire logic branch_valid,
	input wire logic [fbes_pkg::DATA_W-1:0] event_count
);
	logic [31:0] sel_q;
	wire logic cnt_wr = reg_wr && reg_addr == fbes_pkg::OFS_COUNT;
	// selection in force, blanked while software overwrites the count
	wire logic [25:0] on = cnt_wr ? '0 : sel_q[25:0];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_q <= '0;
		end else if (reg_wr && reg_addr == fbes_pkg::OFS_SELECT) begin
			sel_q <= reg_wdata & fbes_pkg::SEL_WR_MASK;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_busy;
		on == 26'h301_1079 && microcode_sequencer_cache_uops != '0;
	endsequence
	sequence s_quiet;
		on == 26'h301_1079 && microcode_sequencer_cache_uops == '0;
	endsequence

	chk_disabled_hold: assert property (!cnt_wr && !sel_q[25] |=> $stable(event_count))
		else $error("count moved while disabled");
	chk_unsup_hold: assert property (on == 26'h200_C189 |=> $stable(event_count))
		else $error("count moved on unsupported selection");
	chk_empty_cycles: assert property (on == 26'h200_0279 |=> event_count == $past(event_count) + 32'($past(decode_queue_empty)))
		else $error("empty cycle count wrong");
	chk_legacy_sum: assert property (on == 26'h200_0479 |=> event_count == $past(event_count) + 32'($past(legacy_decode_path_uops)))
		else $error("legacy uop sum wrong");
	chk_thresh_one: assert property (on == 26'h201_0479 |=> event_count == $past(event_count) + 32'($past(legacy_decode_path_uops) != '0))
		else $error("threshold one count wrong");
	chk_queue_full: assert property (on == 26'h200_0487 |=> event_count == $past(event_count) + 32'($past(instruction_queue_full_stall)))
		else $error("queue full stall count wrong");
	chk_all_branches: assert property (on == 26'h200_FF88 |=> event_count == $past(event_count) + 32'($past(branch_valid)))
		else $error("branch count wrong");
	chk_edge_rise: assert property (s_quiet ##1 s_busy |=> event_count == $past(event_count) + 32'h1)
		else $error("activation not counted");
	chk_edge_once: assert property (s_busy ##1 s_busy |=> $stable(event_count))
		else $error("busy cycle counted in edge mode");
endmodule : fbes_event_select_sva

bind fbes_event_select fbes_event_select_sva #(.UOP_W(UOP_W)) u_sva (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
	.decode_queue_empty, .legacy_decode_path_uops, .microcode_sequencer_cache_uops, .instruction_queue_full_stall,
	.branch_valid, .event_count);

// ===== bench/fbes_event_select_test.sv
// fbes_event_select_test: random event traffic against a reference count for many selections
// assumes: fbes_frontend_model drives the event lines, the bench drives the register port
`timescale 1ns/10ps
module fbes_event_select_test;
	localparam int U = 3;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic run = 1'b0;
	logic [7:0] reg_addr = '0;
	logic [31:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata, event_count, exp_cnt, sel_q, d;
	logic event_count_active, sup, cmp, prev_q;
	logic [4*U-1:0] uops;
	logic [10:0] flags;
	logic [5:0] branch_class;
	int unsigned raw, t;
	int n_errors = 0;
	int checks_done = 0;
	logic [15:0] cfg16 [] = '{16'h0279, 16'h0479, 16'h0879, 16'h1079, 16'h2079, 16'h3079, 16'h2479, 16'h1879,
		16'h3C79, 16'h0280, 16'h0185, 16'h0285, 16'h0485, 16'h1085, 16'h0187, 16'h0487, 16'h4188, 16'h8188,
		16'h8288, 16'h8488, 16'h8888, 16'h9088, 16'hA088, 16'hC188, 16'hC288, 16'hC488, 16'hC888, 16'hD088,
		16'hFF88, 16'h4189, 16'h8189, 16'h8489, 16'h8889, 16'h9089, 16'hA089, 16'hC189, 16'h0179, 16'h0480};
	logic [31:0] cfgx [] = '{32'h0201_1079, 32'h0301_1079, 32'h0202_3C79, 32'h0201_0479, 32'h0000_FF88};

	fbes_frontend_model #(.UOP_W(U)) u_front (.ref_clk, .run, .uops, .flags, .branch_class);
	fbes_event_select #(.UOP_W(U)) uut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.decode_queue_empty(flags[0]), .legacy_decode_path_uops(uops[U-1:0]), .decoded_uop_cache_uops(uops[2*U-1:U]),
		.microcode_sequencer_cache_uops(uops[3*U-1:2*U]), .microcode_sequencer_legacy_uops(uops[4*U-1:3*U]),
		.instruction_fetch_miss(flags[1]), .translation_miss_walk(flags[2]), .translation_walk_done(flags[3]),
		.page_miss_handler_busy(flags[4]), .second_level_translation_buffer_hit(flags[5]),
		.length_changing_prefix_stall(flags[6]), .instruction_queue_full_stall(flags[7]), .branch_valid(flags[8]),
		.branch_class, .branch_taken(flags[9]), .branch_mispredicted(flags[10]), .event_count_active, .event_count);

	always #25 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////////////////////
	// per-cycle raw amount for a selection, ok low when unsupported
	function automatic int unsigned raw_of(input logic [31:0] s, output logic ok);
		logic [7:0] q;
		q = s[15:8];
		ok = 1'b0;
		raw_of = 0;
		case (s[7:0])
			8'h79: begin
				ok = q inside {8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h30, 8'h24, 8'h18, 8'h3C};
				raw_of = q == 8'h02 ? flags[0] : (q[2] ? uops[U-1:0] : 0) + (q[3] ? uops[2*U-1:U] : 0)
					+ (q[4] ? uops[3*U-1:2*U] : 0) + (q[5] ? uops[4*U-1:3*U] : 0);
			end
			8'h80: begin
				ok = q == 8'h02;
				raw_of = flags[1];
			end
			8'h85: begin
				ok = q inside {8'h01, 8'h02, 8'h04, 8'h10};
				raw_of = q[0] ? flags[2] : q[1] ? flags[3] : q[2] ? flags[4] : flags[5];
			end
			8'h87: begin
				ok = q inside {8'h01, 8'h04};
				raw_of = q[0] ? flags[6] : flags[7];
			end
			8'h88, 8'h89: begin
				ok = s[0] ? q inside {8'h41, 8'h81, 8'h84, 8'h88, 8'h90, 8'hA0} : q inside {8'h41, 8'h81, 8'h82,
					8'h84, 8'h88, 8'h90, 8'hA0, 8'hC1, 8'hC2, 8'hC4, 8'hC8, 8'hD0, 8'hFF};
				raw_of = flags[8] && (branch_class & q[5:0]) != 0 && (flags[9] ? q[7] : q[6]) && (!s[0] || flags[10]);
			end
			default: ;
		endcase
	endfunction : raw_of

	// reference counter fed from the same port traffic
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_q <= '0;
			exp_cnt <= '0;
			prev_q <= 1'b0;
		end else begin
			raw = raw_of(sel_q, sup);
			t = sel_q[23:16];
			cmp = sup && raw >= (t == 0 ? 1 : t);
			prev_q <= cmp;
			if (reg_wr && reg_addr == fbes_pkg::OFS_SELECT) sel_q <= reg_wdata & fbes_pkg::SEL_WR_MASK;
			if (reg_wr && reg_addr == fbes_pkg::OFS_COUNT) exp_cnt <= reg_wdata;
			else if (sel_q[25] && sup) exp_cnt <= exp_cnt + (sel_q[24] ? 32'(cmp && !prev_q) : t == 0 ? raw : 32'(raw >= t));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		v = reg_rdata;
	endtask : rd

	// random preload, random traffic, then a quiet read-back
	task automatic run_cfg(input logic [31:0] s);
		wr(fbes_pkg::OFS_SELECT, s);
		wr(fbes_pkg::OFS_COUNT, $urandom);
		run <= 1'b1;
		repeat (40) @(posedge ref_clk);
		run <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rd(fbes_pkg::OFS_COUNT, d);
		check("count", d, exp_cnt);
		check("event_count", event_count, exp_cnt);
		check("active", 32'(event_count_active), 32'(s[25] && sup));
		rd(fbes_pkg::OFS_STATUS, d);
		check("status", d, {30'h0, prev_q, sup});
	endtask : run_cfg

	task automatic finish_test();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	initial begin
		repeat (5000) @(posedge ref_clk);
		n_errors++;
		finish_test();
	end

	initial begin
		void'($urandom(81607));
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(fbes_pkg::OFS_SELECT, d);
		check("select_reset", d, fbes_pkg::SELECT_RESET);
		rd(fbes_pkg::OFS_STATUS, d);
		check("status_reset", d, 32'h0000_0000);
		wr(fbes_pkg::OFS_SELECT, 32'hFFFF_FFFF);
		rd(fbes_pkg::OFS_SELECT, d);
		check("select_mask", d, fbes_pkg::SEL_WR_MASK);
		wr(8'h0C, 32'h1234_5678);
		rd(8'h0C, d);
		check("unmapped", d, 32'h0000_0000);
		foreach (cfg16[i]) run_cfg({16'h0200, cfg16[i]});
		foreach (cfgx[i]) run_cfg(cfgx[i]);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(fbes_pkg::OFS_COUNT, d);
		check("count_reset", d, fbes_pkg::COUNT_RESET);
		check("event_count_reset", event_count, fbes_pkg::COUNT_RESET);
		finish_test();
	end
endmodule : fbes_event_select_test
